// ===== verilog/instruction_word_decode.sv
// Program step decoder and sequencer for the 48-bit one's-complement machine.
//
// Behaviour
// RULE1: Operation code is top six instruction bits.
// RULE2: Fetch pair; upper first, then lower.
// RULE3: Skip omits lower only, on satisfied test.
// RULE4: Skips act only from upper position.
// RULE5: Upper address is word bits 24-38.
// RULE6: Execution address is low fifteen bits.
// RULE7: Index code bits add index register.
// RULE8: Index code selects eight subinstruction variants.
// RULE9: One's complement; top bit is sign.
// RULE10: Data words are 48 bits wide.
// RULE11: Codes 00 and 77 fault and stop.
// RULE12: Codes 01-07 shift by indexed count; code 04 enters aux instead.
// RULE13: Enter loads indexed address, sign extended.
// RULE14: Code 14 adds storage operand to accumulator.
// RULE15: Partial add toggles bits without carries.
// RULE16: Codes 40-42 set, clear, toggle masked bits.
// RULE17: Code 34 normalizes, stores remaining count.
// RULE18: Codes 66-67 masked descending search, skip.
// RULE19: Codes 22-23 test register, jump or return.
// RULE20: Code 75 jumps on key, or return.
// RULE21: Code 76 halts on condition, then jumps.
// RULE22: Return jump records resume point, then transfers.
// RULE23: Code 74 activates channel, selects, or skips.
`timescale 1ns/1ps

module instruction_word_decode
	import decode_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset,
	// Storage read port
	output logic             rd_req,
	output logic [14:0]      rd_addr,
	input  wire logic        rd_valid,
	input  wire logic [47:0] rd_data,
	// Storage write port
	output logic             wr_req,
	output logic [14:0]      wr_addr,
	output logic [47:0]      wr_data,
	input  wire logic        wr_ack,
	// Console
	input  wire logic [2:0]  key_switch,
	input  wire logic        start_key,
	output logic             halted,
	// External function
	output logic             chan_activate,
	output logic [2:0]       chan_num,
	output logic             ext_select,
	output logic [14:0]      ext_code,
	input  wire logic        sense_cond,
	// Status
	output logic             fault,
	output logic [5:0]       fault_code,
	output logic [47:0]      acc,
	output logic [47:0]      aux,
	output logic [14:0]      prog_addr,
	output logic             lower_active
);

	core_t s;
	core_t n;

	logic [23:0] ins;
	logic [5:0]  op;
	logic [2:0]  jj;
	logic [14:0] ma;
	logic [14:0] kk;
	logic [47:0] yy;
	logic [2:0]  keys;
	logic [47:0] msk;

	// RULE5: upper instruction is word bits 24 to 47, its address in bits 24 to 38.
	assign ins = s.lo ? s.w[23:0] : s.w[UPPER_LSB +: INS_W];
	// RULE1: operation code taken from the top six bits.
	assign op = ins[OPC_LSB +: 6];
	assign jj = ins[IDX_LSB +: 3];
	// RULE6: execution address is the low fifteen bits.
	assign ma = ins[14:0];
	// RULE7: index register zero always holds zero, so code 0 means no indexing.
	assign kk = ma + s.bx[jj];
	// RULE13: sign of the indexed address fills every higher stage.
	assign yy = {{33{kk[14]}}, kk};
	assign keys = s.s2[4:2];
	assign msk = rd_data & s.q;

	// RULE9: one's complement sum with end-around carry.
	function automatic logic [47:0] oc_add(logic [47:0] x, logic [47:0] y);
		logic [48:0] t;
		t = {1'b0, x} + {1'b0, y};
		return t[47:0] + {47'h0, t[48]};
	endfunction

	// Left shifts are end-around, as the registers are closed one's complement rings.
	function automatic logic [47:0] rot48(logic [47:0] x, logic [14:0] c);
		logic [95:0] t;
		t = {x, x} << (c % 15'd48);
		return t[95:48];
	endfunction

	function automatic logic [95:0] rot96(logic [95:0] x, logic [14:0] c);
		logic [191:0] t;
		t = {x, x} << (c % 15'd96);
		return t[191:96];
	endfunction

	function automatic logic is_zero(logic [47:0] x);
		return (x == 48'h0000_0000_0000) || (&x);
	endfunction

	// RULE2: after the upper instruction the lower follows; after the lower, next step.
	function automatic core_t adv(core_t x, logic skip);
		// RULE3: a satisfied skip drops only the lower instruction.
		// RULE4: from the lower position there is nothing left to skip.
		if (!x.lo && !skip) begin
			x.lo = 1'b1;
			x.st = s_exec;
		end else begin
			x.p   = x.p + 15'h0001;
			x.adr = x.p;
			x.lo  = 1'b0;
			x.st  = s_fetch;
		end
		return x;
	endfunction

	function automatic core_t go_to(core_t x, logic [14:0] t, logic r);
		// RULE22: resume point stored as a jump word at the target, entry one beyond.
		if (r) begin
			x.wd  = {key_cond_jump, 3'b000, x.p + 15'h0001, 24'h00_0000};
			x.adr = t;
			x.tgt = t + 15'h0001;
			x.st  = s_write;
		end else begin
			x.p   = t;
			x.adr = t;
			x.lo  = 1'b0;
			x.st  = s_fetch;
		end
		return x;
	endfunction

	always_comb begin
		logic        done;
		logic        skp;
		logic        cond;
		logic [95:0] pr;
		logic [47:0] rg;
		done = 1'b0;
		skp  = 1'b0;
		cond = 1'b0;
		pr   = {s.a, s.q};
		rg   = s.a;
		n    = s;
		n.ca = 1'b0;
		n.es = 1'b0;
		n.s1 = {key_switch, start_key, sense_cond};
		n.s2 = s.s1;
		n.sp = s.s2[1];
		case (s.st)
			s_fetch: begin
				// RULE2 RULE10: one 48-bit storage word brings both instructions.
				if (rd_valid) begin
					n.w  = rd_data;
					n.lo = 1'b0;
					n.st = s_exec;
				end
			end
			s_exec: begin
				done = 1'b1;
				// RULE8: the index code picks the subinstruction inside the jump, halt and channel cases.
				case (op)
					// RULE11: inadmissible codes stop the machine.
					fault_code_low, fault_code_high: begin
						done  = 1'b0;
						n.flt = 1'b1;
						n.fc  = op;
						n.st  = s_fault;
					end
					// RULE12: right shifts keep the sign, count is indexed.
					accumulator_shift_right: n.a = 48'($signed(s.a) >>> kk);
					aux_shift_right: n.q = 48'($signed(s.q) >>> kk);
					pair_shift_right: begin
						pr  = 96'($signed({s.a, s.q}) >>> kk);
						n.a = pr[95:48];
						n.q = pr[47:0];
					end
					accumulator_shift_left: n.a = rot48(s.a, kk);
					aux_shift_left: n.q = rot48(s.q, kk);
					pair_shift_left: begin
						pr  = rot96({s.a, s.q}, kk);
						n.a = pr[95:48];
						n.q = pr[47:0];
					end
					// RULE13: enter loads the sign-extended indexed address.
					load_immediate_accumulator: n.a = yy;
					load_immediate_aux: n.q = yy;
					op_add, masked_bit_set, masked_bit_clear, masked_bit_toggle: begin
						done  = 1'b0;
						n.adr = kk;
						n.st  = s_oprd;
					end
					// RULE17: shift allowance comes from the indexed address.
					normalize_accumulator: begin
						done  = 1'b0;
						n.cnt = kk;
						n.st  = s_scale;
					end
					// RULE18: word count from the index register, downward from m.
					masked_equal_search, masked_greater_search: begin
						done  = 1'b0;
						n.cnt = s.bx[jj];
						n.adr = ma;
						n.st  = s_srch;
					end
					// RULE19: zero, nonzero, positive, negative; upper half returns.
					accumulator_cond_jump, aux_cond_jump: begin
						rg = (op == aux_cond_jump) ? s.q : s.a;
						case (jj[1:0])
							2'd0: cond = is_zero(rg);
							2'd1: cond = !is_zero(rg);
							2'd2: cond = !rg[47];
							default: cond = rg[47];
						endcase
						if (cond) begin
							done = 1'b0;
							n    = go_to(n, ma, jj[2]);
						end
					end
					// RULE20: designator 0 always, 1 to 3 on the matching key.
					key_cond_jump: begin
						cond = (jj[1:0] == 2'd0) || keys[jj[1:0] - 2'd1];
						if (cond) begin
							done = 1'b0;
							n    = go_to(n, ma, jj[2]);
						end
					end
					// RULE21: halt when the condition holds, transfer after restart.
					key_cond_halt: begin
						done = 1'b0;
						cond = (jj[1:0] == 2'd0) || keys[jj[1:0] - 2'd1];
						if (cond) begin
							n.tgt = ma;
							n.rj  = jj[2];
							n.st  = s_stop;
						end else begin
							n = go_to(n, ma, jj[2]);
						end
					end
					// RULE23: select equipment, activate channel or sense and skip.
					channel_function: begin
						n.ec = ma;
						if (jj == 3'd0) begin
							n.es = 1'b1;
						end else if (jj == 3'd7) begin
							skp = s.s2[0];
						end else begin
							n.ca = 1'b1;
							n.cn = jj;
						end
					end
					default: begin
					end
				endcase
				if (done) begin
					n = adv(n, skp);
				end
			end
			s_oprd: begin
				if (rd_valid) begin
					case (op)
						// RULE14: sum of accumulator and operand.
						op_add: n.a = oc_add(s.a, rd_data);
						// RULE16: only bits under ones in the operand change.
						masked_bit_set: n.a = s.a | rd_data;
						masked_bit_clear: n.a = s.a & ~rd_data;
						// RULE15: toggling under the addend ones is a carry-free add.
						default: n.a = s.a ^ rd_data;
					endcase
					n = adv(n, 1'b0);
				end
			end
			s_scale: begin
				// RULE17: stop at |A| >= .5 or exhausted allowance; remainder to index.
				if ((s.cnt == 15'h0000) || (s.a[47] != s.a[46])) begin
					if (jj != 3'd0) begin
						n.bx[jj] = s.cnt;
					end
					n = adv(n, 1'b0);
				end else begin
					n.a   = {s.a[46:0], s.a[47]};
					n.cnt = s.cnt - 15'h0001;
				end
			end
			s_srch: begin
				if (s.cnt == 15'h0000) begin
					n = adv(n, 1'b0);
				end else begin
					n.adr = s.adr - 15'h0001;
					n.cnt = s.cnt - 15'h0001;
					n.st  = s_srch_rd;
				end
			end
			s_srch_rd: begin
				if (rd_valid) begin
					// RULE18: masked word equal to, or above, the accumulator is a hit.
					if (op == masked_equal_search) begin
						cond = (msk == s.a);
					end else begin
						cond = ($signed(msk) > $signed(s.a));
					end
					if (cond) begin
						n = adv(n, 1'b1);
					end else begin
						n.st = s_srch;
					end
				end
			end
			s_write: begin
				if (wr_ack) begin
					n = go_to(n, s.tgt, 1'b0);
				end
			end
			s_stop: begin
				// Restart on a rising edge so a held key does not run through.
				if (s.s2[1] && !s.sp) begin
					n = go_to(n, s.tgt, s.rj);
				end
			end
			s_fault: begin
			end
			default: n.st = s_fetch;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s     <= '0;
			s.st  <= s_fetch;
			s.p   <= RST_PROG_ADDR;
			s.adr <= RST_PROG_ADDR;
			s.w   <= RST_WORD;
		end else begin
			s <= n;
		end
	end

	assign rd_req        = (s.st == s_fetch) || (s.st == s_oprd) || (s.st == s_srch_rd);
	assign rd_addr       = s.adr;
	assign wr_req        = (s.st == s_write);
	assign wr_addr       = s.adr;
	assign wr_data       = s.wd;
	assign halted        = (s.st == s_stop) || (s.st == s_fault);
	assign chan_activate = s.ca;
	assign chan_num      = s.cn;
	assign ext_select    = s.es;
	assign ext_code      = s.ec;
	assign fault         = s.flt;
	assign fault_code    = s.fc;
	assign acc           = s.a;
	assign aux           = s.q;
	assign prog_addr     = s.p;
	assign lower_active  = s.lo;

endmodule

// ===== verilog/decode_pkg.sv
// Constants and types shared by the instruction word decoder.
package decode_pkg;

	// Word, instruction and address widths.
	localparam int WORD_W = 48;
	localparam int INS_W  = 24;
	localparam int ADDR_W = 15;

	// Field positions inside one 24-bit instruction.
	localparam int OPC_LSB = 18;
	localparam int IDX_LSB = 15;

	// Upper instruction position inside the 48-bit program step.
	localparam int UPPER_LSB = 24;

	// Reset values.
	localparam logic [14:0] RST_PROG_ADDR = 15'h0000;
	localparam logic [47:0] RST_WORD      = 48'h0000_0000_0000;

	// Operation codes (octal value in the comment).
	localparam logic [5:0] fault_code_low             = 6'h00; // 00
	localparam logic [5:0] accumulator_shift_right    = 6'h01; // 01
	localparam logic [5:0] aux_shift_right            = 6'h02; // 02
	localparam logic [5:0] pair_shift_right           = 6'h03; // 03
	localparam logic [5:0] load_immediate_aux         = 6'h04; // 04
	localparam logic [5:0] accumulator_shift_left     = 6'h05; // 05
	localparam logic [5:0] aux_shift_left             = 6'h06; // 06
	localparam logic [5:0] pair_shift_left            = 6'h07; // 07
	localparam logic [5:0] load_immediate_accumulator = 6'h08; // 10
	localparam logic [5:0] op_add                     = 6'h0c; // 14
	localparam logic [5:0] accumulator_cond_jump      = 6'h12; // 22
	localparam logic [5:0] aux_cond_jump              = 6'h13; // 23
	localparam logic [5:0] normalize_accumulator      = 6'h1c; // 34
	localparam logic [5:0] masked_bit_set             = 6'h20; // 40
	localparam logic [5:0] masked_bit_clear           = 6'h21; // 41
	localparam logic [5:0] masked_bit_toggle          = 6'h22; // 42
	localparam logic [5:0] masked_equal_search        = 6'h36; // 66
	localparam logic [5:0] masked_greater_search      = 6'h37; // 67
	localparam logic [5:0] channel_function           = 6'h3c; // 74
	localparam logic [5:0] key_cond_jump              = 6'h3d; // 75
	localparam logic [5:0] key_cond_halt              = 6'h3e; // 76
	localparam logic [5:0] fault_code_high            = 6'h3f; // 77

	typedef enum logic [3:0] {
		s_fetch, s_exec, s_oprd, s_scale, s_srch, s_srch_rd, s_write, s_stop, s_fault
	} state_t;

	typedef struct packed {
		state_t          st;
		logic [14:0]     p;
		logic            lo;
		logic [47:0]     w;
		logic [47:0]     a;
		logic [47:0]     q;
		logic [7:0][14:0] bx;
		logic [14:0]     cnt;
		logic [14:0]     adr;
		logic [14:0]     tgt;
		logic            rj;
		logic [47:0]     wd;
		logic            flt;
		logic [5:0]      fc;
		logic            ca;
		logic [2:0]      cn;
		logic            es;
		logic [14:0]     ec;
		logic [4:0]      s1;
		logic [4:0]      s2;
		logic            sp;
	} core_t;

endpackage

// ===== dv/core_store.sv
// Storage model that answers program step reads and return jump writes.
`timescale 1ns/1ps
module core_store (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset,
	// Read port
	input  wire logic        rd_req,
	input  wire logic [14:0] rd_addr,
	output logic             rd_valid,
	output logic [47:0]      rd_data,
	// Write port
	input  wire logic        wr_req,
	input  wire logic [14:0] wr_addr,
	input  wire logic [47:0] wr_data,
	output logic             wr_ack,
	// Answer delay in cycles
	input  wire logic [1:0]  dly
);
	logic [47:0] mem [64];
	logic [1:0]  cnt;
	// One wait counter serves both ports, since the block never reads and writes at once.
	always @(posedge clock) begin
		rd_valid <= 1'b0;
		wr_ack   <= 1'b0;
		// Unanswered data lines keep changing so a stale word never looks valid.
		rd_data  <= ~rd_data;
		if (reset || !(rd_req || wr_req) || rd_valid || wr_ack) begin
			cnt <= 2'h0;
		end else if (cnt != dly) begin
			cnt <= cnt + 2'h1;
		end else if (rd_req) begin
			rd_valid <= 1'b1;
			rd_data  <= mem[rd_addr[5:0]];
		end else begin
			wr_ack            <= 1'b1;
			mem[wr_addr[5:0]] <= wr_data;
		end
	end
endmodule

// ===== dv/word_decode_assertions.sv
// Concurrent checks on the decoder's storage, console and channel ports.
`timescale 1ns/1ps
module word_decode_assertions (
	// Clock and reset
	input wire logic        clock,
	input wire logic        reset,
	// Storage
	input wire logic        rd_req,
	input wire logic [14:0] rd_addr,
	input wire logic        rd_valid,
	input wire logic        wr_req,
	input wire logic [14:0] wr_addr,
	input wire logic [47:0] wr_data,
	input wire logic        wr_ack,
	// Console and channels
	input wire logic        halted,
	input wire logic        chan_activate,
	input wire logic [2:0]  chan_num,
	input wire logic        ext_select,
	input wire logic        fault,
	input wire logic [5:0]  fault_code
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	sequence rd_waiting;
		rd_req && !rd_valid;
	endsequence
	sequence wr_done;
		wr_req && wr_ack;
	endsequence
	rd_hold_a: assert property (rd_waiting |=> rd_req && $stable(rd_addr))
		else $error("read request moved before data arrived");
	wr_hold_a: assert property (wr_req && !wr_ack |=> wr_req && $stable({wr_addr, wr_data}))
		else $error("write request moved before acknowledge");
	wr_word_a: assert property (wr_req |-> wr_data[47:39] == 9'h1e8 && wr_data[23:0] == 24'h0)
		else $error("resume word has wrong form");
	wr_resume_a: assert property (wr_done |=> rd_req && rd_addr == $past(wr_addr) + 15'h1)
		else $error("no fetch after resume word");
	fault_hold_a: assert property (fault |=> fault && $stable(fault_code))
		else $error("fault not sticky");
	fault_code_a: assert property (fault |-> halted && (fault_code == 6'h00 || fault_code == 6'h3f))
		else $error("fault without stop or with wrong code");
	chan_num_a: assert property (chan_activate |-> chan_num inside {[3'h1:3'h6]} && !ext_select)
		else $error("channel pulse with bad number");
	halt_idle_a: assert property (halted |-> !rd_req && !wr_req)
		else $error("storage traffic while stopped");
endmodule

// ===== dv/testbench.sv
// Self-checking bench that runs two short programs through the decoder.
`timescale 1ns/1ps
module testbench;
	import decode_pkg::*;
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic [2:0]  key_switch = 3'h0;
	logic        start_key = 1'b0;
	logic        sense_cond = 1'b1;
	logic [1:0]  dly = 2'h0;
	logic        rd_req, rd_valid, wr_req, wr_ack, halted, chan_activate, ext_select;
	logic        fault, lower_active;
	logic [14:0] rd_addr, wr_addr, ext_code, prog_addr, ext_seen;
	logic [47:0] rd_data, wr_data, acc, aux;
	logic [2:0]  chan_num, chan_seen;
	logic [5:0]  fault_code;
	int          err_count = 0;
	int          check_count = 0;
	always #2 clock = ~clock;
	instruction_word_decode dut (.*);
	core_store st (.*);
	always @(posedge clock) begin
		if (chan_activate === 1'b1) chan_seen <= chan_num;
		if (ext_select === 1'b1) ext_seen <= ext_code;
	end
	function automatic logic [23:0] ins(logic [5:0] op, logic [2:0] b, logic [14:0] m);
		return {op, b, m};
	endfunction
	task automatic chk(string name, logic [47:0] exp, logic [47:0] got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %s exp %h got %h", name, exp, got);
		end
	endtask
	task automatic wait_halt(logic lvl);
		int i;
		i = 0;
		@(negedge clock);
		while (halted !== lvl && i < 500) begin
			@(negedge clock);
			i++;
		end
		chk("halted", {47'h0, lvl}, {47'h0, halted});
	endtask
	// The start key passes two sync flops, so it is held until the stop is left.
	task automatic restart();
		@(posedge clock);
		start_key <= 1'b1;
		wait_halt(1'b0);
		@(posedge clock);
		start_key <= 1'b0;
		wait_halt(1'b1);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		$display("FAIL watchdog exp done got timeout");
		end_sim();
	end
	initial begin
		foreach (st.mem[i]) st.mem[i] = 48'h0000_0000_0000;
		st.mem[0] = {ins(load_immediate_accumulator, 3'h0, 15'h4005),
			ins(load_immediate_aux, 3'h0, 15'h0012)};
		st.mem[1] = {ins(masked_bit_set, 3'h0, 15'h0020), ins(masked_bit_toggle, 3'h0, 15'h0021)};
		st.mem[2] = {ins(key_cond_halt, 3'h0, 15'h0003), 24'h00_0000};
		st.mem[3] = {ins(accumulator_cond_jump, 3'h3, 15'h0005), 24'h00_0000};
		st.mem[5] = {ins(aux_cond_jump, 3'h0, 15'h0000), ins(op_add, 3'h0, 15'h0022)};
		st.mem[6] = {ins(channel_function, 3'h7, 15'h0001), 24'h00_0000};
		st.mem[7] = {ins(channel_function, 3'h2, 15'h0055), ins(channel_function, 3'h0, 15'h0123)};
		st.mem[8] = {ins(key_cond_jump, 3'h4, 15'h0030), 24'h00_0000};
		st.mem[9] = {ins(fault_code_high, 3'h0, 15'h0000), 24'h00_0000};
		st.mem[49] = {ins(accumulator_shift_right, 3'h0, 15'h0004),
			ins(key_cond_halt, 3'h0, 15'h0030)};
		st.mem[32] = 48'h0000_0000_00f0;
		st.mem[33] = 48'h0000_0000_0f0f;
		st.mem[34] = 48'h0000_0000_0005;
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		wait_halt(1'b1);
		chk("acc", 48'hffff_ffff_cffa, acc);
		chk("aux", 48'h0000_0000_0012, aux);
		chk("fault", 48'h0000_0000_0000, {47'h0, fault});
		$display("test enter and masked bits done");
		@(posedge clock);
		dly <= 2'h3;
		restart();
		chk("acc", 48'hffff_ffff_fcff, acc);
		chk("chan", 48'h0000_0000_0002, {45'h0, chan_seen});
		chk("ext", 48'h0000_0000_0123, {33'h0, ext_seen});
		chk("resume", 48'hf400_0900_0000, st.mem[48]);
		chk("fault", 48'h0000_0000_0000, {47'h0, fault});
		chk("lower", 48'h0000_0000_0001, {47'h0, lower_active});
		chk("addr", 48'h0000_0000_0031, {33'h0, prog_addr});
		$display("test jumps and channels done");
		restart();
		chk("fault", 48'h0000_0000_0001, {47'h0, fault});
		chk("code", 48'h0000_0000_003f, {42'h0, fault_code});
		$display("test fault done");
		// A second reset clears the sticky fault and runs scale, search and key jumps.
		@(posedge clock);
		reset      <= 1'b1;
		key_switch <= 3'h2;
		foreach (st.mem[i]) st.mem[i] = 48'h0000_0000_0000;
		st.mem[0] = {ins(load_immediate_accumulator, 3'h0, 15'h0003),
			ins(normalize_accumulator, 3'h1, 15'h0030)};
		st.mem[1] = {ins(load_immediate_aux, 3'h1, 15'h0000),
			ins(pair_shift_left, 3'h0, 15'h0002)};
		st.mem[2] = {ins(load_immediate_accumulator, 3'h0, 15'h0005),
			ins(masked_bit_clear, 3'h0, 15'h0020)};
		st.mem[3] = {ins(masked_equal_search, 3'h1, 15'h0024), 24'h00_0000};
		st.mem[4] = {ins(key_cond_jump, 3'h2, 15'h0006), 24'h00_0000};
		st.mem[6] = {ins(pair_shift_right, 3'h0, 15'h0001),
			ins(channel_function, 3'h7, 15'h0001)};
		st.mem[7] = {ins(key_cond_halt, 3'h0, 15'h0000), 24'h00_0000};
		// Only the third word below the search address matches, so a wrong start or count faults.
		st.mem[32] = 48'h0000_0000_00f1;
		st.mem[33] = 48'h0000_0000_00f4;
		st.mem[34] = 48'h0000_0000_000f;
		st.mem[35] = 48'h0000_0000_000f;
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		wait_halt(1'b1);
		chk("acc", 48'h0000_0000_0002, acc);
		chk("aux", 48'h0000_0000_0006, aux);
		chk("fault", 48'h0000_0000_0000, {47'h0, fault});
		chk("addr", 48'h0000_0000_0007, {33'h0, prog_addr});
		$display("test scale, search and keys done");
		end_sim();
	end
endmodule
bind instruction_word_decode word_decode_assertions chk_i (.*);
